// ===== pkg/fpes_pkg.sv
/*
 Constants and carrier types for the flash command/status host controller.
 Assumes a 100 MHz system clock and a parallel NOR flash on async pins.
*/
package fpes_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int PROG_US = 200;
    localparam int PROG_ACC_US = 100;
    localparam int CHIP_S = 15;
    localparam int CHIP_ACC_S = 8;
    localparam int SECT_MS = 400;
    localparam int SECT_ACC_MS = 150;
    localparam int PROG_CYC = PROG_US * CLK_MHZ;
    localparam int PROG_ACC_CYC = PROG_ACC_US * CLK_MHZ;
    localparam longint CHIP_CYC = longint'(CHIP_S) * 1000000 * CLK_MHZ;
    localparam longint CHIP_ACC_CYC = longint'(CHIP_ACC_S) * 1000000 * CLK_MHZ;
    localparam int SECT_CYC = SECT_MS * 1000 * CLK_MHZ;
    localparam int SECT_ACC_CYC = SECT_ACC_MS * 1000 * CLK_MHZ;
    localparam int STROBE_NS = 60;
    localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_HIGH_NS = 50;
    localparam int MIN_HIGH_CYC = (MIN_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 32;
    localparam logic [11:0] ADR_555 = 12'h555;
    localparam logic [11:0] ADR_2AA = 12'h2AA;
    localparam logic [7:0] D_AA = 8'hAA;
    localparam logic [7:0] D_55 = 8'h55;
    localparam logic [7:0] D_80 = 8'h80;
    localparam logic [7:0] D_PROG = 8'hA0;
    localparam logic [7:0] D_90 = 8'h90;
    localparam logic [7:0] D_F0 = 8'hF0;
    localparam logic [7:0] D_CHIP = 8'h10;
    localparam logic [7:0] D_SECT = 8'h30;
    localparam int TOGGLE_BIT = 6;
    localparam logic [1:0] OP_PROG = 2'h0;
    localparam logic [1:0] OP_SECT = 2'h1;
    localparam logic [1:0] OP_CHIP = 2'h2;
    localparam logic [1:0] OP_ID = 2'h3;
    typedef struct packed {
        logic csN;
        logic oeN;
        logic weN;
        logic dataOe;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
    } fpes_pins_s;
    typedef struct packed {
        logic [1:0] op;
        logic accel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fpes_cmd_s;
endpackage

// ===== hw/fpes_sync.sv
/*
 Three-stage input synchroniser with agreement filter.
 Assumes one clock; input is asynchronous to it.
*/
module fpes_sync #(
    parameter int W = 16
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1Reg;
    logic [W-1:0] s2Reg;
    logic [W-1:0] s3Reg;
    wire logic agree = (s2Reg == s3Reg);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1Reg <= '0;
            s2Reg <= '0;
            s3Reg <= '0;
            dout <= '0;
        end else begin
            s1Reg <= din;
            s2Reg <= s1Reg;
            s3Reg <= s2Reg;
            if (agree) begin
                dout <= s3Reg;
            end
        end
    end
endmodule // fpes_sync

// ===== hw/fpes_host.sv
/*
 Host controller: issues program, erase and ID command sequences to the
 flash pins, polls the toggle bit to completion and reads ID codes.
 Assumes the flash data bus is resolved outside from dataOe.
*/
module fpes_host (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic cmdValid,
    input wire fpes_pkg::fpes_cmd_s cmd,
    input wire logic [fpes_pkg::DATA_W-1:0] flashDin,
    output fpes_pkg::fpes_pins_s pins,
    output logic cmdReady,
    output logic doneValid,
    output logic timeoutErr,
    output logic [fpes_pkg::DATA_W-1:0] idData
);
    typedef enum {ST_IDLE, ST_WLOW, ST_WHIGH, ST_PLOW, ST_PHIGH, ST_DONE} fpes_state_e;
    fpes_state_e stateReg;
    fpes_state_e stateNext;
    logic [2:0] stepReg;
    logic [fpes_pkg::TMR_W-1:0] phaseReg;
    logic [63:0] busyReg;
    logic havePrevReg;
    logic prevBitReg;
    logic haveOneReg;
    logic [fpes_pkg::DATA_W-1:0] readReg;
    fpes_pkg::fpes_cmd_s cmdReg;
    logic [fpes_pkg::DATA_W-1:0] syncData;

    fpes_sync #(.W(fpes_pkg::DATA_W)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .din(flashDin),
        .dout(syncData)
    );

    // Sequence table: 2 unlock writes then op-specific ones; ID entry and exit are 3 writes
    wire logic [2:0] lastStep = (cmdReg.op == fpes_pkg::OP_PROG) ? 3'h3 :
        ((cmdReg.op == fpes_pkg::OP_ID) ? 3'h2 : 3'h5);
    wire logic stepAdv = (stateReg == ST_WHIGH) && (stateNext == ST_WLOW);
    // Pins load the step being entered, so a write never opens on stale data
    wire logic [2:0] stepNext = (stateReg == ST_IDLE) ? 3'h0 :
        (stepAdv ? stepReg + 3'h1 : stepReg);
    logic [11:0] seqAddr;
    logic [7:0] seqData;
    always_comb begin
        seqAddr = fpes_pkg::ADR_555;
        seqData = fpes_pkg::D_AA;
        case (stepNext)
            3'h0: begin
                seqAddr = fpes_pkg::ADR_555;
                seqData = fpes_pkg::D_AA;
            end
            3'h1: begin
                seqAddr = fpes_pkg::ADR_2AA;
                seqData = fpes_pkg::D_55;
            end
            3'h2: begin
                seqAddr = fpes_pkg::ADR_555;
                case (cmdReg.op)
                    fpes_pkg::OP_PROG: seqData = fpes_pkg::D_PROG;
                    // Data bit 0 selects entry or the long exit form
                    fpes_pkg::OP_ID: seqData = cmdReg.data[0] ? fpes_pkg::D_F0 : fpes_pkg::D_90;
                    default: seqData = fpes_pkg::D_80;
                endcase
            end
            3'h3: begin
                seqAddr = cmdReg.addr[11:0];
                seqData = (cmdReg.op == fpes_pkg::OP_PROG) ? cmdReg.data[7:0] : fpes_pkg::D_AA;
                if (cmdReg.op != fpes_pkg::OP_PROG) begin
                    seqAddr = fpes_pkg::ADR_555;
                end
            end
            3'h4: begin
                seqAddr = fpes_pkg::ADR_2AA;
                seqData = fpes_pkg::D_55;
            end
            default: begin
                // Chip erase ends at 555 with 10H, sector at its address with 30H
                seqAddr = (cmdReg.op == fpes_pkg::OP_CHIP) ? fpes_pkg::ADR_555 : cmdReg.addr[11:0];
                seqData = (cmdReg.op == fpes_pkg::OP_CHIP) ? fpes_pkg::D_CHIP : fpes_pkg::D_SECT;
            end
        endcase
    end

    // Program data keeps its full word; command writes use low byte only
    wire logic progData = (cmdReg.op == fpes_pkg::OP_PROG) && (stepNext == 3'h3);
    wire logic [fpes_pkg::DATA_W-1:0] wrWord = progData ? cmdReg.data :
        {8'h00, seqData};
    wire logic [fpes_pkg::ADDR_W-1:0] wrAddr = (progData ||
        (cmdReg.op == fpes_pkg::OP_SECT && stepNext == 3'h5)) ? cmdReg.addr :
        {{(fpes_pkg::ADDR_W-12){1'b0}}, seqAddr};
    wire logic [fpes_pkg::TMR_W-1:0] limitProg = fpes_pkg::TMR_W'(cmdReg.accel ?
        fpes_pkg::PROG_ACC_CYC : fpes_pkg::PROG_CYC);
    wire logic [63:0] busyLimit = (cmdReg.op == fpes_pkg::OP_PROG) ? 64'(limitProg) :
        (cmdReg.op == fpes_pkg::OP_SECT) ? 64'(cmdReg.accel ? fpes_pkg::SECT_ACC_CYC :
        fpes_pkg::SECT_CYC) : (cmdReg.accel ? 64'(fpes_pkg::CHIP_ACC_CYC) :
        64'(fpes_pkg::CHIP_CYC));
    wire logic strobeDone = phaseReg >= fpes_pkg::TMR_W'(fpes_pkg::STROBE_CYC - 1);
    wire logic highDone = phaseReg >= fpes_pkg::TMR_W'(fpes_pkg::MIN_HIGH_CYC - 1);
    wire logic curBit = readReg[fpes_pkg::TOGGLE_BIT];
    wire logic settled = havePrevReg && (curBit == prevBitReg);
    wire logic overTime = busyReg >= busyLimit;

    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            ST_IDLE: stateNext = cmdValid ? ST_WLOW : ST_IDLE;
            ST_WLOW: stateNext = strobeDone ? ST_WHIGH : ST_WLOW;
            ST_WHIGH: begin
                if (highDone && stepReg != lastStep) begin
                    stateNext = ST_WLOW;
                end else if (highDone) begin
                    stateNext = (cmdReg.op == fpes_pkg::OP_ID && !cmdReg.data[0]) ?
                        ST_PLOW : (cmdReg.op == fpes_pkg::OP_ID ? ST_DONE : ST_PLOW);
                end
            end
            ST_PLOW: stateNext = strobeDone ? ST_PHIGH : ST_PLOW;
            ST_PHIGH: begin
                if (highDone) begin
                    stateNext = (cmdReg.op == fpes_pkg::OP_ID || settled || overTime) ?
                        ST_DONE : ST_PLOW;
                end
            end
            default: stateNext = ST_IDLE;
        endcase
    end

    wire logic phaseWrap = stateNext != stateReg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stateReg <= ST_IDLE;
            stepReg <= 3'h0;
            phaseReg <= '0;
            busyReg <= '0;
            cmdReg <= '0;
        end else begin
            stateReg <= stateNext;
            phaseReg <= phaseWrap ? '0 : phaseReg + 1'b1;
            busyReg <= (stateReg == ST_IDLE) ? 64'h0 : busyReg + 64'h1;
            if (stateReg == ST_IDLE && cmdValid) begin
                cmdReg <= cmd;
            end
            stepReg <= stepNext;
        end
    end

    // Word latched as the read strobe ends; once OE rises the bus holds nothing valid
    wire logic readEnd = (stateReg == ST_PLOW) && (stateNext == ST_PHIGH);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            haveOneReg <= 1'b0;
            havePrevReg <= 1'b0;
            prevBitReg <= 1'b0;
            readReg <= '0;
        end else if (stateReg == ST_WHIGH) begin
            haveOneReg <= 1'b0;
            havePrevReg <= 1'b0;
        end else if (readEnd) begin
            haveOneReg <= 1'b1;
            havePrevReg <= haveOneReg;
            prevBitReg <= curBit;
            readReg <= syncData;
        end
    end

    // Pin drive: OE stays high through every write strobe
    wire logic wrPhase = (stateNext == ST_WLOW) || (stateNext == ST_WHIGH);
    wire logic rdLow = stateNext == ST_PLOW;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pins <= '{csN: 1'b1, oeN: 1'b1, weN: 1'b1, dataOe: 1'b0, addr: '0, dout: '0};
            cmdReady <= 1'b0;
            doneValid <= 1'b0;
            timeoutErr <= 1'b0;
            idData <= '0;
        end else begin
            pins.weN <= !(stateNext == ST_WLOW);
            pins.csN <= !((stateNext == ST_WLOW) || rdLow);
            pins.oeN <= !rdLow;
            pins.dataOe <= wrPhase;
            if (wrPhase) begin
                pins.addr <= wrAddr;
                pins.dout <= wrWord;
            end else if (stateReg == ST_WHIGH && cmdReg.op == fpes_pkg::OP_ID) begin
                // Entry reads address 0 or 1 for the two codes
                pins.addr <= {{(fpes_pkg::ADDR_W-1){1'b0}}, cmdReg.addr[0]};
            end
            cmdReady <= stateNext == ST_IDLE;
            doneValid <= stateReg == ST_DONE;
            if (stateReg == ST_PHIGH && stateNext == ST_DONE) begin
                timeoutErr <= overTime && !settled && cmdReg.op != fpes_pkg::OP_ID;
                // Last read is array data once settled, ID code in ID mode
                idData <= readReg;
            end
        end
    end

    a_oe_in_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        !pins.weN |-> pins.oeN) else $error("oe low during write");
    a_cs_in_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        !pins.weN |-> !pins.csN && pins.dataOe) else $error("write without cs");
    a_high_gap: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(pins.oeN) |-> pins.oeN[*5]) else $error("oe high too short");
    a_addr_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        (stateReg == ST_PHIGH && $past(stateReg) == ST_PHIGH) |-> $stable(pins.addr))
        else $error("poll address moved");
    a_low_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!pins.weN && !progData) |-> pins.dout[15:8] == 8'h00)
        else $error("upper byte set");
    a_final_chip: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!pins.weN && stepReg == 3'h5 && cmdReg.op == fpes_pkg::OP_CHIP) |->
        pins.addr[11:0] == fpes_pkg::ADR_555 && pins.dout[7:0] == fpes_pkg::D_CHIP)
        else $error("bad chip final write");
    a_final_sect: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!pins.weN && stepReg == 3'h5 && cmdReg.op == fpes_pkg::OP_SECT) |->
        pins.dout[7:0] == fpes_pkg::D_SECT) else $error("bad sector final write");
    a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        doneValid |-> cmdReady ##1 !doneValid) else $error("done not one cycle");
    a_busy_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
        (stateReg == ST_PHIGH && cmdReg.op == fpes_pkg::OP_PROG) |->
        busyReg <= 64'(limitProg) + 64'h40) else $error("program overran");
    a_single_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(pins.oeN) |-> !pins.csN && pins.weN) else $error("read strobe bad");

    c_prog: cover property (@(posedge clk_sys) disable iff (!rstn)
        doneValid && cmdReg.op == fpes_pkg::OP_PROG);
    c_sect: cover property (@(posedge clk_sys) disable iff (!rstn)
        doneValid && cmdReg.op == fpes_pkg::OP_SECT);
    c_id: cover property (@(posedge clk_sys) disable iff (!rstn)
        doneValid && cmdReg.op == fpes_pkg::OP_ID);
    c_timeout: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(timeoutErr));
endmodule // fpes_host

// ===== verification/fpes_flash_model.sv
/*
 Behavioural flash device on the host's async pins: command decode,
 toggle-bit status, ID codes and protocol checks on the host side.
 Assumes the bench resolves the data bus from dataOe and dq.
*/
module fpes_flash_model #(
    parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h005A // Arbitrary value
) (
    input fpes_pkg::fpes_pins_s pins,
    input logic powerOk,
    input int busyPolls,
    output logic [15:0] dq,
    output int protoErr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wrAct, rdAct, idMode, busy, st6, pollSet;
    logic [119:0] hist;
    logic [20:0] wAddr, pollAddr;
    logic [15:0] wData, rdVal;
    logic [15:0] mem [int];
    int busyLeft;
    realtime lastEnd;
    assign wrAct = !pins.csN && !pins.weN;
    assign rdAct = !pins.csN && !pins.oeN && pins.weN;
    // Released bus shows the inverse, so a stale word never passes
    assign dq = rdAct ? rdVal : ~rdVal;
    initial begin
        protoErr = 0;
        idMode = 0;
        busy = 0;
        st6 = 0;
        pollSet = 0;
        rdVal = 16'h0000;
        hist = '0;
        lastEnd = -100.0;
    end
    always @(negedge powerOk) begin
        idMode = 0;
        busy = 0;
    end
    task automatic startBusy();
        busy = 1;
        busyLeft = busyPolls;
        pollSet = 0;
        hist = '0;
    endtask
    task automatic decode();
        int doomed[$];
        hist = {hist[99:0], wAddr[11:0], wData[7:0]};
        if (hist[79:20] == {20'h555AA, 20'h2AA55, 20'h555A0}) begin
            mem[int'(wAddr)] = mem.exists(int'(wAddr)) ? mem[int'(wAddr)] & wData : wData;
            startBusy();
        end else if (hist[119:20] == {20'h555AA, 20'h2AA55, 20'h55580, 20'h555AA, 20'h2AA55}) begin
            if (wData[7:0] == 8'h10) begin
                if (wAddr[11:0] != 12'h555) protoErr++;
                mem.delete();
            end else if (wData[7:0] == 8'h30) begin
                // Keys collected first: deleting inside the walk is unsafe
                foreach (mem[k]) if (k[20:12] == wAddr[20:12]) doomed.push_back(k);
                foreach (doomed[i]) mem.delete(doomed[i]);
            end else protoErr++;
            startBusy();
        end else if (wData[7:0] == 8'hF0) idMode = 0;
        else if (hist[59:0] == {20'h555AA, 20'h2AA55, 20'h55590}) idMode = 1;
    endtask
    always @(posedge wrAct) begin
        if (!pins.oeN) protoErr++;
        #20;
        wAddr = pins.addr;
        wData = pins.dout;
        // Writes during an operation are dropped, as the device does
        if (!busy) decode();
    end
    always @(posedge rdAct) begin
        if ($realtime - lastEnd < 50.0) protoErr++;
        if (busy) begin
            if (pollSet && pins.addr != pollAddr) protoErr++;
            pollAddr = pins.addr;
            pollSet = 1;
            busyLeft--;
            busy = busyLeft > 0;
        end
        if (busy) begin
            st6 = !st6;
            rdVal = 16'(st6) << 6;
        end else if (idMode) begin
            rdVal = (pins.addr[20:1] == '0) ? (pins.addr[0] ? DEV_CODE : MFR_CODE) : 16'h0000;
        end else begin
            rdVal = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 16'hFFFF;
        end
    end
    always @(negedge rdAct) lastEnd = $realtime;
endmodule // fpes_flash_model

// ===== verification/testbench.sv
/*
 Self-checking bench for the flash host controller with a device model.
 Assumes the model decodes the controller's command sequences.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value
    localparam logic [15:0] DEV = 16'h005A; // Arbitrary value
    logic clk_sys, rstn, cmdValid, cmdReady, doneValid, timeoutErr;
    fpes_pkg::fpes_cmd_s cmd;
    fpes_pkg::fpes_pins_s pins;
    logic [15:0] idData, flashDq, flashDin;
    int busyPolls, protoErr, err_count, cmp_count;
    assign flashDin = pins.dataOe ? pins.dout : flashDq;
    fpes_host i_dut (
        .clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid), .cmd(cmd),
        .flashDin(flashDin), .pins(pins), .cmdReady(cmdReady),
        .doneValid(doneValid), .timeoutErr(timeoutErr), .idData(idData)
    );
    fpes_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_flash (
        .pins(pins), .powerOk(rstn), .busyPolls(busyPolls), .dq(flashDq),
        .protoErr(protoErr)
    );
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic check16(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic run(input logic [1:0] op, input logic acc, input logic [20:0] a,
                       input logic [15:0] d);
        int n;
        n = 0;
        do begin @(negedge clk_sys); n++; end while (cmdReady !== 1'b1 && n < 100);
        check16({15'h0000, cmdReady}, 16'h0001, "ready for command");
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmd <= '{op: op, accel: acc, addr: a, data: d};
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        n = 0;
        do begin @(negedge clk_sys); n++; end while (doneValid !== 1'b1 && n < 20000);
        check16({15'h0000, doneValid}, 16'h0001, "done pulse");
    endtask
    task automatic testIdCodes();
        run(fpes_pkg::OP_ID, 1'b0, 21'h000000, 16'h0000);
        check16(idData, MFR, "maker code");
        run(fpes_pkg::OP_ID, 1'b0, 21'h000001, 16'h0000);
        check16(idData, DEV, "device code");
    endtask
    task automatic testProgram();
        run(fpes_pkg::OP_ID, 1'b0, 21'h000000, 16'h0001);
        run(fpes_pkg::OP_PROG, 1'b0, 21'h012345, 16'hA53C);
        check16(idData, 16'hA53C, "array after exit");
        check16({15'h0000, timeoutErr}, 16'h0000, "program limit");
    endtask
    task automatic testErase();
        run(fpes_pkg::OP_SECT, 1'b1, 21'h012000, 16'h0000);
        check16(idData, 16'hFFFF, "sector erased");
        check16({15'h0000, timeoutErr}, 16'h0000, "sector limit");
        run(fpes_pkg::OP_PROG, 1'b1, 21'h1F0002, 16'h1234);
        run(fpes_pkg::OP_CHIP, 1'b0, 21'h000555, 16'h0000);
        check16(idData, 16'hFFFF, "chip erased");
        check16({15'h0000, timeoutErr}, 16'h0000, "chip limit");
    endtask
    task automatic testPowerDown();
        run(fpes_pkg::OP_ID, 1'b0, 21'h000000, 16'h0000);
        @(posedge clk_sys);
        rstn <= 1'b0;
        @(negedge clk_sys);
        check16({idData[13:0], cmdReady, doneValid}, 16'h0000, "outputs in reset");
        @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(negedge clk_sys);
        check16({idData[13:0], cmdReady, doneValid}, 16'h0002, "outputs after reset");
        run(fpes_pkg::OP_PROG, 1'b0, 21'h000000, 16'h0F0F);
        check16(idData, 16'h0F0F, "array after power loss");
    endtask
    task automatic testTimeout();
        busyPolls = 1000000;
        run(fpes_pkg::OP_PROG, 1'b1, 21'h000100, 16'h00FF);
        check16({15'h0000, timeoutErr}, 16'h0001, "stuck program");
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #600000;
        err_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
    initial begin
        rstn = 1'b0;
        cmdValid = 1'b0;
        cmd = '0;
        busyPolls = 5;
        err_count = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        testIdCodes();
        testProgram();
        testErase();
        testPowerDown();
        check16(16'(protoErr), 16'h0000, "bus protocol");
        testTimeout();
        summarize();
    end
endmodule // testbench
